// ==== verilog/smbg_guard.v ====
`timescale 1ns/1ps
`include "smbg_defines.vh"
// Behaviour
// - Clock low past timeout aborts transaction.
// - Clock high over 50 us resets to idle.
// - Own stretching per message within 25 ms.
// - Accept slave clock 10 to 100 kHz.
// - Master mode clock nominal 51.2 kHz.
// - Slave-only SMBus 1.1, PEC optional.
// - Bus-off after 2 s both low.
module smbg_guard #(
  parameter TOUT_CYC = `SMBG_TOUT_CYC,
  parameter IDLE_CYC = `SMBG_IDLE_CYC,
  parameter SEXT_CYC = `SMBG_SEXT_CYC,
  parameter OFF_CYC = `SMBG_OFF_CYC,
  parameter REL_CYC = `SMBG_REL_CYC,
  parameter MHALF_CYC = `SMBG_MHALF_CYC
) (
  // Clock and reset.
  input wire ref_clk_i,
  input wire nrst_i,
  // Bus pins, open drain; enable low means drive low.
  input wire bus_clock_pin_i,
  output reg bus_clock_pin_o,
  output reg bus_clock_pin_oe_n_o,
  input wire bus_data_pin_i,
  output reg bus_data_pin_o,
  output reg bus_data_pin_oe_n_o,
  // Requests from the protocol engine to pull the lines low, and master mode select.
  input wire stretch_req_i,
  input wire data_low_req_i,
  input wire master_mode_i,
  // Status towards the protocol engine.
  output reg active_o,
  output reg abort_o,
  output reg bus_off_o,
  output reg bus_ready_o,
  output reg budget_hit_o,
  output reg master_tick_o
);
  wire scl; // Synchronised clock line.
  wire sda; // Synchronised data line.
  reg scl_d; // Previous clock level.
  reg sda_d; // Previous data level.
  reg [31:0] low_cnt; // Clock-low run length.
  reg [31:0] high_cnt; // Clock-high run length.
  reg [31:0] sext_cnt; // Own stretch total this message.
  reg [31:0] off_cnt; // Both-low run length.
  reg [31:0] rel_cnt; // Release timer after bus-off.
  reg [31:0] mdiv; // Master clock half-period divider.
  reg releasing; // Waiting out the bus-off release time.
  reg stretching; // We currently pull the clock low.

  // Pins come from outside the clock domain, so each passes two flops
  // before any logic here looks at it.
  smbg_sync u_scl (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i(bus_clock_pin_i),
    .q_o(scl)
  );
  smbg_sync u_sda (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .d_i(bus_data_pin_i),
    .q_o(sda)
  );

  // Start is data falling while clock high; stop is data rising.
  wire start_c = scl && scl_d && sda_d && !sda;
  wire stop_c = scl && scl_d && !sda_d && sda;
  // Timeout and idle events; counters saturate just past the limit.
  wire tout_ev = (low_cnt == TOUT_CYC - 1) && !scl;
  wire idle_ev = (high_cnt == IDLE_CYC - 1) && scl;
  wire sext_ev = stretching && (sext_cnt == SEXT_CYC - 1);
  // Any abort cause that ends the transaction in this cycle.
  wire abort_c = tout_ev || idle_ev || sext_ev;
  // Clock pull wanted and allowed: live, asked for, budget left.
  wire clk_pull_c = active_o && stretch_req_i && !budget_hit_o && !abort_c;

  // Edge history of the synchronised lines.
  // Reset to the idle-high level of the pins, so a quiet bus shows no
  // edge once reset lets go.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // Run-length counters of the clock line. No clock period is
  // checked: any rate inside the slave range is simply followed.
  // Both counters saturate, so an endless quiet bus cannot wrap them
  // round and fake a second event.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      low_cnt <= 32'h0;
      high_cnt <= 32'h0;
    end else begin
      if (scl) begin
        low_cnt <= 32'h0;
      end else if (low_cnt < TOUT_CYC) begin
        low_cnt <= low_cnt + 32'h1;
      end
      if (!scl) begin
        high_cnt <= 32'h0;
      end else if (high_cnt < IDLE_CYC) begin
        high_cnt <= high_cnt + 32'h1;
      end
    end
  end

  // Transaction state: set by start, cleared by stop, timeout, idle, stretch budget.
  // A start in the same cycle as an abort still wins, so no frame lost.
  // The abort pulse fires only for a live transaction, so a stuck line
  // on an idle bus does not flood the engine with aborts.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      active_o <= 1'b0;
      abort_o <= 1'b0;
    end else begin
      abort_o <= active_o && abort_c;
      if (start_c && !bus_off_o) begin
        active_o <= 1'b1;
      end else if (stop_c || abort_c) begin
        active_o <= 1'b0;
      end
    end
  end

  // Own stretch budget summed over a message, reset at start or stop.
  // The master's own budget is its affair; we only endure it.
  // A start or stop opens a fresh budget for the next message.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sext_cnt <= 32'h0;
      budget_hit_o <= 1'b0;
    end else if (start_c || stop_c) begin
      sext_cnt <= 32'h0;
      // A budget event in the same cycle still sets the flag.
      budget_hit_o <= sext_ev;
    end else if (stretching && sext_cnt < SEXT_CYC) begin
      sext_cnt <= sext_cnt + 32'h1;
      if (sext_ev) begin
        budget_hit_o <= 1'b1;
      end
    end
  end

  // Bus-off detection and release timer.
  // While bus-off stands no start is taken, so a shorted bus cannot
  // open a transaction that would only time out again.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      off_cnt <= 32'h0;
      rel_cnt <= 32'h0;
      releasing <= 1'b0;
      bus_off_o <= 1'b0;
      bus_ready_o <= 1'b0;
    end else begin
      if (scl || sda) begin
        off_cnt <= 32'h0;
      end else if (off_cnt < OFF_CYC) begin
        off_cnt <= off_cnt + 32'h1;
      end
      if (!bus_off_o && off_cnt == OFF_CYC - 1 && !scl && !sda) begin
        bus_off_o <= 1'b1;
        bus_ready_o <= 1'b0;
      end else if (bus_off_o && (scl || sda)) begin
        bus_off_o <= 1'b0;
        releasing <= 1'b1;
        rel_cnt <= 32'h0;
      end else if (releasing) begin
        // Ready well inside the 1 ms release allowance.
        if (rel_cnt == REL_CYC / 2) begin
          releasing <= 1'b0;
          bus_ready_o <= 1'b1;
        end else begin
          rel_cnt <= rel_cnt + 32'h1;
        end
      end else if (!bus_off_o) begin
        bus_ready_o <= 1'b1;
      end
    end
  end

  // Master clock divider; ticks toggle a 51.2 kHz bus clock. Unused
  // on the bus since the device answers only as a slave.
  // The divider is held at zero outside master mode, so the first tick
  // comes a full half period after the mode is entered.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      mdiv <= 32'h0;
      master_tick_o <= 1'b0;
    end else if (master_mode_i && mdiv == MHALF_CYC - 1) begin
      mdiv <= 32'h0;
      master_tick_o <= 1'b1;
    end else begin
      mdiv <= master_mode_i ? mdiv + 32'h1 : 32'h0;
      master_tick_o <= 1'b0;
    end
  end

  // Line drivers: pull low only inside a live transaction, so any
  // abort releases both lines until the next start.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      stretching <= 1'b0;
      bus_clock_pin_o <= 1'b0;
      bus_clock_pin_oe_n_o <= 1'b1;
      bus_data_pin_o <= 1'b0;
      bus_data_pin_oe_n_o <= 1'b1;
    end else begin
      // Both enables come from flops, so the pins never glitch low.
      stretching <= clk_pull_c;
      bus_clock_pin_oe_n_o <= !clk_pull_c;
      // The data pull is refused outside a transaction; this keeps a
      // stale engine request off the bus after an abort.
      bus_data_pin_oe_n_o <= !(active_o && data_low_req_i && !abort_c);
    end
  end
endmodule

// ==== inc/smbg_defines.vh ====
`ifndef SMBG_DEFINES_VH
`define SMBG_DEFINES_VH
// Clock rate in kHz.
`define SMBG_CLK_KHZ 200000
// Clock-low timeout window, ms (low and high end).
`define SMBG_TOUT_MIN_MS 25
`define SMBG_TOUT_MAX_MS 35
// Timeout point chosen inside the window, cycles (30 ms).
`define SMBG_TOUT_CYC 6000000
// Bus idle time, us, and cycles (rounded up).
`define SMBG_IDLE_US 50
`define SMBG_IDLE_CYC ((`SMBG_IDLE_US * `SMBG_CLK_KHZ + 999) / 1000)
// Slave and master stretch budgets, ms; cycles for the slave budget only.
`define SMBG_SEXT_MS 25
`define SMBG_SEXT_CYC (`SMBG_SEXT_MS * `SMBG_CLK_KHZ)
`define SMBG_MEXT_MS 10
// Slave clock range, kHz.
`define SMBG_FMIN_KHZ 10
`define SMBG_FMAX_KHZ 100
// Master clock 51.2 kHz in 100 Hz units; half period, rounded down.
`define SMBG_MCLK_HZ10 512
`define SMBG_MHALF_CYC ((`SMBG_CLK_KHZ * 10) / (`SMBG_MCLK_HZ10 * 2))
// Bus-off detect 2 s, release within 1 ms.
`define SMBG_OFF_MS 2000
`define SMBG_OFF_CYC (`SMBG_OFF_MS * `SMBG_CLK_KHZ)
`define SMBG_REL_MS 1
`define SMBG_REL_CYC (`SMBG_REL_MS * `SMBG_CLK_KHZ)
`endif

// ==== verilog/smbg_sync.v ====
`timescale 1ns/1ps
// Two-flop synchroniser for a pin level; pins idle high.
module smbg_sync (
  // Clock and reset.
  input wire ref_clk_i,
  input wire nrst_i,
  // Asynchronous level in, synchronised level out.
  input wire d_i,
  output reg q_o
);
  reg meta; // First stage, read only by the second.
  // Both stages reset to the idle-high bus level.
  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      meta <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ==== dv/smbg_guard_assertions.sv ====
`timescale 1ns/1ps
// Guard checks; the counters follow the raw pin levels.
module smbg_guard_assertions #(
  parameter TOUT_CYC = 200,
  parameter IDLE_CYC = 100,
  parameter OFF_CYC = 500
) (
  // Clock, reset and pins in.
  input wire ref_clk_i, nrst_i, bus_clock_pin_i, bus_data_pin_i,
  // Engine requests.
  input wire stretch_req_i, data_low_req_i, master_mode_i,
  // Pin drivers and status.
  input wire bus_clock_pin_o, bus_clock_pin_oe_n_o, bus_data_pin_o,
  input wire bus_data_pin_oe_n_o, active_o, abort_o, bus_off_o,
  input wire bus_ready_o, budget_hit_o, master_tick_o
);
  // A margin of 6 covers the synchroniser and one register stage.
  int hi_cnt, lo_cnt, off_cnt;
  logic d_q;
  // Data edges also restart the high count; the guard's idle timer restarts only on clock low.
  always @(posedge ref_clk_i) begin
    d_q <= bus_data_pin_i;
    hi_cnt <= (bus_clock_pin_i && d_q == bus_data_pin_i) ? hi_cnt + 1 : 0;
    lo_cnt <= bus_clock_pin_i ? 0 : lo_cnt + 1;
    off_cnt <= (bus_clock_pin_i || bus_data_pin_i) ? 0 : off_cnt + 1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence off_exit_s;
    $fell(bus_off_o);
  endsequence
  pins_zero_a: assert property (!bus_clock_pin_o && !bus_data_pin_o)
    else $error("pin output not zero");
  clock_timeout_a: assert property (lo_cnt > TOUT_CYC + 6 |-> !active_o)
    else $error("no abort on long clock low");
  idle_reset_a: assert property (hi_cnt > IDLE_CYC + 6 |-> !active_o)
    else $error("no reset on long clock high");
  off_entry_a: assert property (off_cnt > OFF_CYC + 6 |-> bus_off_o)
    else $error("bus off not seen");
  off_exit_a: assert property (off_exit_s |-> ##[0:55] bus_ready_o)
    else $error("bus not ready after bus off");
  abort_pulse_a: assert property (abort_o |=> !abort_o)
    else $error("abort longer than one cycle");
  abort_release_a: assert property (abort_o |=>
    bus_clock_pin_oe_n_o && bus_data_pin_oe_n_o) else $error("not released");
  stretch_cause_a: assert property ($fell(bus_clock_pin_oe_n_o) |->
    $past(active_o) && $past(stretch_req_i)) else $error("bad stretch");
  tick_mode_a: assert property (master_tick_o |-> $past(master_mode_i))
    else $error("tick outside master mode");
  data_release_a: assert property (!active_o |=> bus_data_pin_oe_n_o)
    else $error("data pulled outside transaction");
  budget_stop_a: assert property (budget_hit_o |-> bus_clock_pin_oe_n_o)
    else $error("clock pulled after budget used");
endmodule
bind smbg_guard smbg_guard_assertions #(.TOUT_CYC(TOUT_CYC),
  .IDLE_CYC(IDLE_CYC), .OFF_CYC(OFF_CYC)) i_chk (.*);

// ==== dv/smbg_host.sv ====
`timescale 1ns/1ps
// Host master: open-drain pulls only, changed on falling edges.
module smbg_host (
  // Bench clock.
  input wire ref_clk_i,
  // Pull-low requests for the clock and data lines.
  output reg scl_low_o = 1'b0,
  output reg sda_low_o = 1'b0
);
  // Set both pulls, then hold them for n cycles.
  task line(input logic c, input logic d, input int n);
    scl_low_o = c;
    sda_low_o = d;
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Start: data falls while the clock is high.
  task start;
    line(0, 0, 4);
    line(0, 1, 8);
    line(1, 1, 4);
  endtask
  // Stop: data rises while the clock is high.
  task stop;
    line(1, 1, 4);
    line(0, 1, 8);
    line(0, 0, 4);
  endtask
  // Short even pulses, so the host never stretches for long.
  task pulse(input int n);
    repeat (n) begin
      line(0, 1, 16);
      line(1, 1, 16);
    end
  endtask
endmodule

// ==== dv/test_smbus_slave_timeout_guard.sv ====
`timescale 1ns/1ps
module test_smbus_slave_timeout_guard;
  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    miscompares++; $display("mismatch %0t %h %h", $time, g, e); end end
  reg ref_clk_i = 0, nrst_i = 0, stretch = 0, dlow = 0, mm = 0;
  // Short counts keep the run brief.
  localparam int TOUT = 200, IDLE = 100, SEXT = 300;
  localparam int OFF = 500, REL = 50, MHALF = 8;
  wire clk_oe_n, dat_oe_n, act, ab, off, rdy, bh, tk, pc, pd, hs, hd;
  // Open-drain lines: high unless either side pulls low.
  wire scl = clk_oe_n & !hs;
  wire sda = dat_oe_n & !hd;
  int miscompares = 0, tests_run = 0, ticks = 0, aborts = 0, t0;
  // Rows: stretch, data low, then expected clock and data enables.
  logic [3:0] rows [4] = '{4'h3, 4'h9, 4'h6, 4'hC};
  smbg_guard #(.TOUT_CYC(TOUT), .IDLE_CYC(IDLE), .SEXT_CYC(SEXT),
    .OFF_CYC(OFF), .REL_CYC(REL), .MHALF_CYC(MHALF)) i_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .bus_clock_pin_i(scl),
    .bus_clock_pin_o(pc), .bus_clock_pin_oe_n_o(clk_oe_n),
    .bus_data_pin_i(sda), .bus_data_pin_o(pd),
    .bus_data_pin_oe_n_o(dat_oe_n), .stretch_req_i(stretch),
    .data_low_req_i(dlow), .master_mode_i(mm), .active_o(act),
    .abort_o(ab), .bus_off_o(off), .bus_ready_o(rdy),
    .budget_hit_o(bh), .master_tick_o(tk));
  smbg_host i_host (.ref_clk_i(ref_clk_i), .scl_low_o(hs), .sda_low_o(hd));
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  // Count one-cycle pulses so none is missed between checks.
  always @(posedge ref_clk_i) begin
    ticks <= ticks + tk;
    aborts <= aborts + ab;
  end
  task cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task results;
    $display("ran %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    results;
  end
  initial begin
    cyc(12);
    nrst_i = 1;
    cyc(2);
    `CHK({clk_oe_n, dat_oe_n, act, rdy, pc, pd}, 6'h34)
    done("reset");
    i_host.start();
    `CHK(act, 1'b1)
    foreach (rows[i]) begin
      {stretch, dlow} = rows[i][3:2];
      cyc(2);
      `CHK({clk_oe_n, dat_oe_n}, rows[i][1:0])
    end
    {stretch, dlow} = 2'h0;
    i_host.stop();
    `CHK(act, 1'b0)
    done("rows");
    i_host.start();
    t0 = aborts;
    i_host.line(1, 1, TOUT + 15);
    `CHK(aborts - t0, 1)
    `CHK({act, clk_oe_n, dat_oe_n}, 3'h3)
    stretch = 1;
    cyc(3);
    `CHK(clk_oe_n, 1'b1)
    stretch = 0;
    i_host.stop();
    done("timeout");
    i_host.start();
    i_host.pulse(2);
    `CHK(act, 1'b1)
    t0 = aborts;
    i_host.line(0, 1, IDLE + 10);
    `CHK(aborts - t0, 1)
    i_host.stop();
    done("idle");
    i_host.start();
    i_host.line(0, 1, 4);
    repeat (3) begin
      stretch = 1;
      cyc(100);
      stretch = 0;
      cyc(10);
    end
    stretch = 1;
    cyc(20);
    `CHK({bh, clk_oe_n}, 2'h3)
    stretch = 0;
    i_host.stop();
    i_host.start();
    `CHK(bh, 1'b0)
    i_host.stop();
    done("budget");
    i_host.start();
    dlow = 1;
    cyc(2);
    `CHK({act, dat_oe_n}, 2'h2)
    nrst_i = 0;
    cyc(3);
    `CHK({act, dat_oe_n, rdy}, 3'h2)
    nrst_i = 1;
    cyc(3);
    `CHK({act, dat_oe_n, rdy}, 3'h3)
    dlow = 0;
    i_host.stop();
    done("mid reset");
    i_host.line(1, 1, OFF + 20);
    `CHK({off, rdy}, 2'h2)
    i_host.line(0, 0, 0);
    for (t0 = 0; t0 < REL + 5 && rdy !== 1'b1; t0++) cyc(1);
    `CHK({off, rdy}, 2'h1)
    done("bus off");
    t0 = ticks;
    mm = 1;
    cyc(MHALF * 10);
    mm = 0;
    cyc(2);
    `CHK(ticks - t0, 10)
    done("master tick");
    results;
  end
endmodule
